//--- core/exc_regs.vh
`ifndef EXC_REGS_VH
`define EXC_REGS_VH

// register word indices (byte address = index * 4)
`define IDX_ICSR 6'h00
`define IDX_PRIO_TWO 6'h01
`define IDX_PRIO_THREE 6'h02
`define IDX_HCSR 6'h03
`define IDX_TICK_CSR 6'h04
`define IDX_TICK_RELOAD 6'h05
`define IDX_TICK_CURRENT 6'h06
`define IDX_SYSREQ 6'h07
`define IDX_CONFIG 6'h08
`define IDX_FAULT_STATUS 6'h09

// interrupt_control_state_reg fields
`define ICSR_NMI_SET 31
`define ICSR_PSV_SET 28
`define ICSR_PSV_CLR 27
`define ICSR_TICK_SET 26
`define ICSR_TICK_CLR 25
`define ICSR_ANY_PEND 22
`define ICSR_ACTIVE_HI 5
`define ICSR_ACTIVE_LO 0

// priority fields
`define PRIO_SVC_HI 31
`define PRIO_SVC_LO 30
`define PRIO_TICK_HI 31
`define PRIO_TICK_LO 30
`define PRIO_PSV_HI 23
`define PRIO_PSV_LO 22

// handler_control_state_reg, tick_control_status_reg, others
`define HCSR_SVC_PENDED 15
`define TCSR_ENABLE 0
`define TCSR_TICK_INT 1
`define TCSR_COUNT_FLAG 16
`define SYSREQ_CALL 31
`define CONFIG_VECT_RAM 0

// exception numbers
`define EXC_NONE 6'h00
`define EXC_RESET 6'h01
`define EXC_NMI 6'h02
`define EXC_FAULT 6'h03
`define EXC_SVC 6'h0b
`define EXC_PSV 6'h0e
`define EXC_TICK 6'h0f

// urgency keys, lower is more urgent
`define KEY_NMI 3'h0
`define KEY_FAULT 3'h1
`define KEY_CFG_BASE 3'h2
`define KEY_THREAD 3'h7

// vector bases and fixed addresses
`define FLASH_BASE 32'h00000000
`define RAM_BASE 32'h20000000
`define RESET_VEC_ADDR 32'h00000004
`define ROM_NMI_VEC 32'h00000008

// boot rom sequence length and widths
`define BOOT_CYCLES 8'h10
`define TICK_W 24
`define TICK_ONE 24'h000001
`define TICK_ZERO 24'h000000

`endif

//--- core/system_exception_sources.v
// Overview of operation
// RQ1: reset is always enabled, fixed priority minus three
// RQ2: after boot rom, start at flash 0x00000004
// RQ3: leave reset with flash vector table selected
// RQ4: nmi always enabled, fixed priority minus two
// RQ5: hardware line zero raises nmi via active table
// RQ6: software nmi pend-set raises nmi via active table
// RQ7: system call request nmi vectors from boot rom
// RQ8: user access to boot rom is blocked
// RQ9: fault always enabled, priority minus one
// RQ10: no fault status; fault handler may return
// RQ11: supervisor call instruction pends its exception
// RQ12: supervisor call priority in bits 31:30, reg two
// RQ13: supervisor call pended bit readable and writable
// RQ14: pended supervisor set bit makes it pending
// RQ15: pended supervisor clear bit removes pending
// RQ16: pended supervisor priority bits 23:22, reg three
// RQ17: 24-bit tick counter requests at zero if enabled
// RQ18: tick priority in bits 31:30, reg three
// RQ19: tick pend-set bit pends tick exception anytime
// RQ20: tick pend-clear bit removes tick pending
// RQ21: numerically lower priority value is more urgent
// RQ22: ram table at 0x20000000 when bit set
`timescale 1ns/100ps
`include "exc_regs.vh"

module system_exception_sources (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // event sources
  input wire nmi_line_i,
  input wire fault_i,
  input wire svc_i,
  // core handshake
  input wire exc_ack_i,
  input wire exc_return_i,
  output wire exc_req_o,
  output wire [5:0] exc_num_o,
  output wire [31:0] vector_addr_o,
  output wire vector_from_rom_o,
  output wire boot_active_o,
  // boot rom access gate
  input wire rom_req_i,
  output wire rom_grant_o
);

  localparam [2:0] ST_BOOT = 3'h1;
  localparam [2:0] ST_RESET_VEC = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  // configurable priority to urgency key
  function [2:0] cfg_key;
    input [1:0] prio;
    begin
      cfg_key = {1'b0, prio} + `KEY_CFG_BASE;
    end
  endfunction

  reg [2:0] state_r;
  reg [7:0] boot_cnt_r;
  reg ack_r;
  reg [31:0] dat_r;
  reg nmi_s1_r, nmi_s2_r, nmi_s3_r;
  reg nmi_pend_r, syscall_pend_r, fault_pend_r;
  reg svc_pend_r, psv_pend_r, tick_pend_r;
  reg [1:0] svc_prio_r, psv_prio_r, tick_prio_r;
  reg vect_ram_r;
  reg tick_en_r, tick_int_r, count_flag_r;
  reg [`TICK_W-1:0] tick_reload_r, tick_cnt_r;
  reg [2:0] cur_key_r;
  reg [5:0] cur_num_r;
  reg syscall_active_r;
  reg exc_req_r;
  reg [5:0] exc_num_r;
  reg [31:0] vector_addr_r;
  reg vector_rom_r;
  reg rom_grant_r;

  wire req = wb_cyc_i & wb_stb_i;
  wire wr = req & wb_we_i & ack_r;
  wire rd_done = req & ~wb_we_i & ack_r;
  wire [5:0] idx = wb_adr_i[7:2];
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wd = wb_dat_i & wmask;
  wire wr_icsr = wr & (idx == `IDX_ICSR);
  wire wr_p2 = wr & (idx == `IDX_PRIO_TWO);
  wire wr_p3 = wr & (idx == `IDX_PRIO_THREE);
  wire wr_hcsr = wr & (idx == `IDX_HCSR);
  wire wr_tcsr = wr & (idx == `IDX_TICK_CSR);
  wire wr_rel = wr & (idx == `IDX_TICK_RELOAD);
  wire wr_cur = wr & (idx == `IDX_TICK_CURRENT);
  wire wr_sysreq = wr & (idx == `IDX_SYSREQ);
  wire wr_cfg = wr & (idx == `IDX_CONFIG);
  wire nmi_rise = nmi_s2_r & ~nmi_s3_r;
  wire taken = exc_ack_i & exc_req_r;
  wire tick_hit = tick_en_r & (tick_cnt_r == `TICK_ONE);

  // ack one cycle after request; read data latches with ack, writes land on the edge that samples ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read mux, latched together with ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h00000000;
    end else if (req & ~ack_r) begin
      dat_r <= 32'h00000000;
      case (idx)
        `IDX_ICSR: begin
          dat_r[`ICSR_NMI_SET] <= nmi_pend_r;
          dat_r[`ICSR_PSV_SET] <= psv_pend_r;
          dat_r[`ICSR_TICK_SET] <= tick_pend_r;
          dat_r[`ICSR_ANY_PEND] <= nmi_pend_r | syscall_pend_r |
            fault_pend_r | svc_pend_r | psv_pend_r | tick_pend_r;
          dat_r[`ICSR_ACTIVE_HI:`ICSR_ACTIVE_LO] <= cur_num_r;
        end
        `IDX_PRIO_TWO: dat_r[`PRIO_SVC_HI:`PRIO_SVC_LO] <= svc_prio_r;
        `IDX_PRIO_THREE: begin
          dat_r[`PRIO_TICK_HI:`PRIO_TICK_LO] <= tick_prio_r;
          dat_r[`PRIO_PSV_HI:`PRIO_PSV_LO] <= psv_prio_r;
        end
        `IDX_HCSR: dat_r[`HCSR_SVC_PENDED] <= svc_pend_r;
        `IDX_TICK_CSR: begin
          dat_r[`TCSR_ENABLE] <= tick_en_r;
          dat_r[`TCSR_TICK_INT] <= tick_int_r;
          dat_r[`TCSR_COUNT_FLAG] <= count_flag_r;
        end
        `IDX_TICK_RELOAD: dat_r[`TICK_W-1:0] <= tick_reload_r;
        `IDX_TICK_CURRENT: dat_r[`TICK_W-1:0] <= tick_cnt_r;
        `IDX_SYSREQ: dat_r[`SYSREQ_CALL] <= syscall_pend_r;
        `IDX_CONFIG: dat_r[`CONFIG_VECT_RAM] <= vect_ram_r;
        // fault status and unmapped words read zero: no fault detail kept
        default: dat_r <= 32'h00000000; // RQ10
      endcase
    end
  end

  // nmi line comes from another domain: two flops, then edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      {nmi_s3_r, nmi_s2_r, nmi_s1_r} <= 3'h0;
    end else begin
      {nmi_s3_r, nmi_s2_r, nmi_s1_r} <= {nmi_s2_r, nmi_s1_r, nmi_line_i};
    end
  end

  // priority fields, only lanes that are selected change
  always @(posedge clk_i) begin
    if (rst_i) begin
      svc_prio_r <= 2'h0;
      psv_prio_r <= 2'h0;
      tick_prio_r <= 2'h0;
    end else begin
      if (wr_p2 & wb_sel_i[3])
        svc_prio_r <= wd[`PRIO_SVC_HI:`PRIO_SVC_LO]; // RQ12
      if (wr_p3 & wb_sel_i[3])
        tick_prio_r <= wd[`PRIO_TICK_HI:`PRIO_TICK_LO]; // RQ18
      if (wr_p3 & wb_sel_i[2])
        psv_prio_r <= wd[`PRIO_PSV_HI:`PRIO_PSV_LO]; // RQ16
    end
  end

  // vector table select; reset always leaves the flash table in use
  always @(posedge clk_i) begin
    if (rst_i) begin
      vect_ram_r <= 1'b0; // RQ3
    end else if (wr_cfg & wb_sel_i[0]) begin
      vect_ram_r <= wd[`CONFIG_VECT_RAM]; // RQ22
    end
  end

  // tick timer: reload at zero, event on the step down to zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_en_r <= 1'b0;
      tick_int_r <= 1'b0;
      count_flag_r <= 1'b0;
      tick_reload_r <= `TICK_ZERO;
      tick_cnt_r <= `TICK_ZERO;
    end else begin
      if (wr_tcsr & wb_sel_i[0]) begin
        tick_en_r <= wd[`TCSR_ENABLE];
        tick_int_r <= wd[`TCSR_TICK_INT];
      end
      if (wr_rel) begin
        tick_reload_r <= (tick_reload_r & ~wmask[`TICK_W-1:0]) |
          wd[`TICK_W-1:0];
      end
      // a write of any value to current clears it
      if (wr_cur) begin
        tick_cnt_r <= `TICK_ZERO;
      end else if (tick_en_r) begin
        tick_cnt_r <= (tick_cnt_r == `TICK_ZERO) ? tick_reload_r :
          tick_cnt_r - `TICK_ONE; // RQ17
      end
      // flag clears on read of the status register; a hit wins
      if (tick_hit)
        count_flag_r <= 1'b1;
      else if (rd_done & (idx == `IDX_TICK_CSR))
        count_flag_r <= 1'b0;
    end
  end

  // pending flags: clear first, any set in the same cycle wins
  always @(posedge clk_i) begin
    if (rst_i) begin
      nmi_pend_r <= 1'b0;
      syscall_pend_r <= 1'b0;
      fault_pend_r <= 1'b0;
      svc_pend_r <= 1'b0;
      psv_pend_r <= 1'b0;
      tick_pend_r <= 1'b0;
    end else begin
      if (taken & (exc_num_r == `EXC_NMI) & ~vector_rom_r)
        nmi_pend_r <= 1'b0;
      if (nmi_rise)
        nmi_pend_r <= 1'b1; // RQ5
      if (wr_icsr & wd[`ICSR_NMI_SET])
        nmi_pend_r <= 1'b1; // RQ6
      if (taken & (exc_num_r == `EXC_NMI) & vector_rom_r)
        syscall_pend_r <= 1'b0;
      if (wr_sysreq & wd[`SYSREQ_CALL])
        syscall_pend_r <= 1'b1; // RQ7
      if (taken & (exc_num_r == `EXC_FAULT))
        fault_pend_r <= 1'b0;
      if (fault_i)
        fault_pend_r <= 1'b1; // RQ9
      if (taken & (exc_num_r == `EXC_SVC))
        svc_pend_r <= 1'b0;
      if (wr_hcsr & wb_sel_i[1])
        svc_pend_r <= wd[`HCSR_SVC_PENDED]; // RQ13
      if (svc_i)
        svc_pend_r <= 1'b1; // RQ11
      if ((taken & (exc_num_r == `EXC_PSV)) |
          (wr_icsr & wd[`ICSR_PSV_CLR]))
        psv_pend_r <= 1'b0; // RQ15
      if (wr_icsr & wd[`ICSR_PSV_SET])
        psv_pend_r <= 1'b1; // RQ14
      if ((taken & (exc_num_r == `EXC_TICK)) |
          (wr_icsr & wd[`ICSR_TICK_CLR]))
        tick_pend_r <= 1'b0; // RQ20
      if ((tick_hit & tick_int_r) | (wr_icsr & wd[`ICSR_TICK_SET]))
        tick_pend_r <= 1'b1; // RQ19
    end
  end

  // arbitration, scanned low to high urgency so ties go to lower number
  reg [2:0] win_key;
  reg [5:0] win_num;
  reg win_rom;
  always @* begin
    win_key = `KEY_THREAD;
    win_num = `EXC_NONE;
    win_rom = 1'b0;
    if (tick_pend_r & (cfg_key(tick_prio_r) <= win_key)) begin
      win_key = cfg_key(tick_prio_r); // RQ21
      win_num = `EXC_TICK;
    end
    if (psv_pend_r & (cfg_key(psv_prio_r) <= win_key)) begin
      win_key = cfg_key(psv_prio_r); // RQ21
      win_num = `EXC_PSV;
    end
    if (svc_pend_r & (cfg_key(svc_prio_r) <= win_key)) begin
      win_key = cfg_key(svc_prio_r); // RQ21
      win_num = `EXC_SVC;
    end
    if (fault_pend_r) begin
      win_key = `KEY_FAULT; // RQ9
      win_num = `EXC_FAULT;
    end
    if (nmi_pend_r) begin
      win_key = `KEY_NMI; // RQ4
      win_num = `EXC_NMI;
    end
    if (syscall_pend_r) begin
      win_key = `KEY_NMI;
      win_num = `EXC_NMI;
      win_rom = 1'b1;
    end
  end

  wire preempt = (state_r == ST_RUN) & (win_key < cur_key_r);
  wire [31:0] tbl_base = vect_ram_r ? `RAM_BASE : `FLASH_BASE;

  // reset sequence: boot rom, reset vector, then normal running
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_BOOT; // RQ1
      boot_cnt_r <= 8'h00;
    end else begin
      case (state_r)
        ST_BOOT: begin
          boot_cnt_r <= boot_cnt_r + 8'h01;
          if (boot_cnt_r == `BOOT_CYCLES - 8'h01)
            state_r <= ST_RESET_VEC;
        end
        ST_RESET_VEC: begin
          if (taken)
            state_r <= ST_RUN;
        end
        ST_RUN: state_r <= ST_RUN;
        default: state_r <= ST_BOOT;
      endcase
    end
  end

  // presented request; follows the current winner each cycle and drops when the core takes it or the winner is cleared
  always @(posedge clk_i) begin
    if (rst_i | (state_r == ST_BOOT)) begin
      exc_req_r <= 1'b0;
      exc_num_r <= `EXC_NONE;
      vector_addr_r <= `FLASH_BASE;
      vector_rom_r <= 1'b1;
    end else if (state_r == ST_RESET_VEC) begin
      exc_req_r <= ~taken;
      exc_num_r <= `EXC_RESET;
      vector_addr_r <= `RESET_VEC_ADDR; // RQ2
      vector_rom_r <= 1'b0;
    end else if (taken) begin
      exc_req_r <= 1'b0;
    end else begin
      exc_req_r <= preempt;
      exc_num_r <= win_num;
      vector_rom_r <= win_rom;
      vector_addr_r <= win_rom ? `ROM_NMI_VEC :
        tbl_base + {24'h000000, win_num, 2'b00}; // RQ7 RQ22
    end
  end

  // running level; one nesting level, return goes back to thread
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_key_r <= `KEY_THREAD;
      cur_num_r <= `EXC_NONE;
      syscall_active_r <= 1'b0;
    end else if (taken & (state_r == ST_RUN)) begin
      cur_key_r <= win_key_of(exc_num_r);
      cur_num_r <= exc_num_r;
      syscall_active_r <= vector_rom_r;
    end else if (exc_return_i) begin
      cur_key_r <= `KEY_THREAD; // RQ10
      cur_num_r <= `EXC_NONE;
      syscall_active_r <= 1'b0;
    end
  end

  // key of a taken exception number
  function [2:0] win_key_of;
    input [5:0] num;
    begin
      case (num)
        `EXC_NMI: win_key_of = `KEY_NMI;
        `EXC_FAULT: win_key_of = `KEY_FAULT;
        `EXC_SVC: win_key_of = cfg_key(svc_prio_r);
        `EXC_PSV: win_key_of = cfg_key(psv_prio_r);
        `EXC_TICK: win_key_of = cfg_key(tick_prio_r);
        default: win_key_of = `KEY_THREAD;
      endcase
    end
  endfunction

  // rom is only open to boot code and the system call handler
  always @(posedge clk_i) begin
    if (rst_i) begin
      rom_grant_r <= 1'b0;
    end else begin
      rom_grant_r <= rom_req_i &
        ((state_r == ST_BOOT) | syscall_active_r); // RQ8
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign exc_req_o = exc_req_r;
  assign exc_num_o = exc_num_r;
  assign vector_addr_o = vector_addr_r;
  assign vector_from_rom_o = vector_rom_r;
  assign boot_active_o = state_r[0];
  assign rom_grant_o = rom_grant_r;

endmodule // system_exception_sources

//--- sim/exc_sva.sv
`timescale 1ns/100ps
module exc_sva (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // watched ports
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire exc_ack_i,
  input wire exc_req_o,
  input wire [5:0] exc_num_o,
  input wire [31:0] vector_addr_o,
  input wire vector_from_rom_o,
  input wire boot_active_o,
  input wire rom_req_i,
  input wire rom_grant_o
);
  // one clock domain, so one default for all
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // reset itself is the cause here, so this one is never disabled
  chk_reset_state:
  assert property (disable iff (1'b0)
    rst_i |=> boot_active_o && !exc_req_o && !wb_ack_o)
  else $error("reset state wrong");
  chk_boot_quiet:
  assert property (boot_active_o |-> !exc_req_o)
  else $error("exception during boot");
  chk_boot_entry:
  assert property ($fell(boot_active_o) |-> ##[0:2] (exc_req_o &&
    exc_num_o == 6'h01 && vector_addr_o == 32'h00000004 &&
    !vector_from_rom_o))
  else $error("reset entry wrong");
  // table slot is number times four, base flash or ram
  chk_vec_table:
  assert property (exc_req_o && !vector_from_rom_o && exc_num_o != 6'h01
    |-> vector_addr_o[7:0] == {exc_num_o, 2'b00} &&
    (vector_addr_o[31:8] == 24'h0 || vector_addr_o[31:8] == 24'h200000))
  else $error("vector address wrong");
  chk_rom_vector:
  assert property (exc_req_o && vector_from_rom_o |->
    exc_num_o == 6'h02 && vector_addr_o == 32'h00000008)
  else $error("rom vector wrong");
  chk_take_drop:
  assert property (exc_req_o && exc_ack_i |=> !exc_req_o)
  else $error("request stands after take");
  chk_num_legal:
  assert property (exc_req_o |-> exc_num_o inside
    {6'h01, 6'h02, 6'h03, 6'h0b, 6'h0e, 6'h0f})
  else $error("illegal exception number");
  chk_rom_boot:
  assert property (rom_req_i && boot_active_o |=> rom_grant_o)
  else $error("boot rom access refused in boot");
  chk_rom_cause:
  assert property (rom_grant_o |-> $past(rom_req_i))
  else $error("rom grant without request");
  chk_wb_ack:
  assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
  else $error("bus ack wrong");
endmodule // exc_sva

bind system_exception_sources exc_sva u_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .exc_ack_i(exc_ack_i), .exc_req_o(exc_req_o), .exc_num_o(exc_num_o),
  .vector_addr_o(vector_addr_o), .vector_from_rom_o(vector_from_rom_o),
  .boot_active_o(boot_active_o), .rom_req_i(rom_req_i),
  .rom_grant_o(rom_grant_o));

//--- sim/core_model.sv
`timescale 1ns/100ps
module core_model (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // presented exception
  input wire en_i,
  input wire [3:0] dly_i,
  input wire req_i,
  input wire [5:0] num_i,
  input wire [31:0] addr_i,
  input wire rom_i,
  // handshake back
  output logic ack_o,
  output logic ret_o,
  // record of the last take
  output logic [7:0] taken_o,
  output logic [5:0] num_o,
  output logic [31:0] addr_o,
  output logic rom_o
);
  logic busy;
  logic [3:0] cnt;

  // take after dly_i cycles, run handler four cycles, then return
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    ret_o <= 1'b0;
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      taken_o <= 8'h00;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h3) begin
        ret_o <= 1'b1;
        busy <= 1'b0;
        cnt <= 4'h0;
      end
    end else if (req_i && !ack_o && en_i) begin
      if (cnt >= dly_i) begin
        ack_o <= 1'b1;
        busy <= 1'b1;
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      cnt <= 4'h0;
    end
    // record at the take edge, where ack and request are both seen
    if (!rst_i && ack_o && req_i) begin
      num_o <= num_i;
      addr_o <= addr_i;
      rom_o <= rom_i;
      taken_o <= taken_o + 8'h01;
    end
  end
endmodule // core_model

//--- sim/tb_system_exception_sources.sv
`timescale 1ns/100ps
module tb_system_exception_sources;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, exc_ack_i, exc_return_i, exc_req_o;
  logic nmi_line_i = 1'b0, fault_i = 1'b0, svc_i = 1'b0, rom_req_i = 1'b0;
  logic [5:0] exc_num_o, c_num;
  logic [31:0] vector_addr_o, c_addr;
  logic vector_from_rom_o, boot_active_o, rom_grant_o, c_rom;
  logic en = 1'b1;
  logic [3:0] dly = 4'h0;
  logic [7:0] taken, seen;
  integer error_cnt = 0, total_checks = 0, p;

  always #2 clk_i = ~clk_i;

  system_exception_sources u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_line_i(nmi_line_i),
    .fault_i(fault_i), .svc_i(svc_i), .exc_ack_i(exc_ack_i),
    .exc_return_i(exc_return_i), .exc_req_o(exc_req_o),
    .exc_num_o(exc_num_o), .vector_addr_o(vector_addr_o),
    .vector_from_rom_o(vector_from_rom_o), .boot_active_o(boot_active_o),
    .rom_req_i(rom_req_i), .rom_grant_o(rom_grant_o));

  core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .dly_i(dly),
    .req_i(exc_req_o), .num_i(exc_num_o), .addr_i(vector_addr_o),
    .rom_i(vector_from_rom_o), .ack_o(exc_ack_i), .ret_o(exc_return_i),
    .taken_o(taken), .num_o(c_num), .addr_o(c_addr), .rom_o(c_rom));

  task close_out;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // one classic cycle; request held until ack is sampled high
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      close_out();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // wait for the core to take the next exception, compare its vector
  task exp_exc(input logic [5:0] n, input logic [31:0] a, input logic r);
    integer k;
    k = 0;
    while (taken === seen && k < 300) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 300) begin
      error_cnt++;
      close_out();
    end
    seen = taken;
    cmp({26'h0, c_num}, {26'h0, n});
    cmp(c_addr, a);
    cmp({31'h0, c_rom}, {31'h0, r});
  endtask

  task pulse_events(input logic f, input logic s);
    @(posedge clk_i);
    fault_i <= f;
    svc_i <= s;
    @(posedge clk_i);
    fault_i <= 1'b0;
    svc_i <= 1'b0;
  endtask

  initial begin
    seen = 8'h00;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rom_req_i <= 1'b1;
    @(posedge clk_i);
    cmp({31'h0, boot_active_o}, 32'h1);
    @(posedge clk_i);
    cmp({31'h0, rom_grant_o}, 32'h1);
    rom_req_i <= 1'b0;
    exp_exc(6'h01, 32'h00000004, 1'b0);
    wb(1'b0, 8'h20, 0); cmp(rd, 32'h0);
    wb(1'b0, 8'h24, 0); cmp(rd, 32'h0);
    wb(1'b0, 8'h3c, 0); cmp(rd, 32'h0);
    rom_req_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp({31'h0, rom_grant_o}, 32'h0);
    rom_req_i <= 1'b0;
    $display("test reset and boot done");
    // every priority value through each two-bit field
    for (p = 0; p < 4; p++) begin
      wb(1'b1, 8'h04, {p[1:0], 30'h0});
      wb(1'b0, 8'h04, 0); cmp(rd & 32'hc0000000, {p[1:0], 30'h0});
      wb(1'b1, 8'h08, {p[1:0], 6'h0, p[1:0], 22'h0});
      wb(1'b0, 8'h08, 0);
      cmp(rd & 32'hc0c00000, {p[1:0], 6'h0, p[1:0], 22'h0});
    end
    $display("test priority fields done");
    // lower value wins: pended supervisor 1, tick 2, supervisor call 3
    en <= 1'b0;
    wb(1'b1, 8'h08, 32'h80400000);
    wb(1'b1, 8'h0c, 32'h00008000);
    wb(1'b1, 8'h00, 32'h14000000);
    wb(1'b0, 8'h00, 0); cmp(rd & 32'h14400000, 32'h14400000);
    wb(1'b0, 8'h0c, 0); cmp(rd & 32'h00008000, 32'h00008000);
    en <= 1'b1;
    dly <= 4'h3;
    exp_exc(6'h0e, 32'h00000038, 1'b0);
    exp_exc(6'h0f, 32'h0000003c, 1'b0);
    exp_exc(6'h0b, 32'h0000002c, 1'b0);
    dly <= 4'h0;
    $display("test arbitration done");
    en <= 1'b0;
    wb(1'b1, 8'h00, 32'h14000000);
    wb(1'b1, 8'h00, 32'h0a000000);
    wb(1'b0, 8'h00, 0); cmp(rd & 32'h14000000, 32'h0);
    wb(1'b1, 8'h0c, 32'h00008000);
    wb(1'b1, 8'h0c, 32'h0);
    wb(1'b0, 8'h0c, 0); cmp(rd & 32'h00008000, 32'h0);
    en <= 1'b1;
    repeat (20) @(posedge clk_i);
    cmp({24'h0, taken}, {24'h0, seen});
    $display("test pend clear done");
    // fixed ranks: nmi over fault over a configurable one
    en <= 1'b0;
    pulse_events(1'b1, 1'b1);
    wb(1'b1, 8'h00, 32'h80000000);
    en <= 1'b1;
    exp_exc(6'h02, 32'h00000008, 1'b0);
    exp_exc(6'h03, 32'h0000000c, 1'b0);
    exp_exc(6'h0b, 32'h0000002c, 1'b0);
    $display("test fixed ranks done");
    wb(1'b1, 8'h20, 32'h1);
    wb(1'b1, 8'h00, 32'h80000000);
    exp_exc(6'h02, 32'h20000008, 1'b0);
    nmi_line_i <= 1'b1;
    exp_exc(6'h02, 32'h20000008, 1'b0);
    nmi_line_i <= 1'b0;
    wb(1'b1, 8'h1c, 32'h80000000);
    exp_exc(6'h02, 32'h00000008, 1'b1);
    rom_req_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp({31'h0, rom_grant_o}, 32'h1);
    rom_req_i <= 1'b0;
    wb(1'b1, 8'h20, 32'h0);
    $display("test nmi paths done");
    // counting without tick interrupt enable only raises the flag
    wb(1'b1, 8'h14, 32'h3);
    wb(1'b1, 8'h18, 32'h0);
    wb(1'b1, 8'h10, 32'h1);
    repeat (12) @(posedge clk_i);
    wb(1'b0, 8'h10, 0); cmp(rd & 32'h00010000, 32'h00010000);
    cmp({24'h0, taken}, {24'h0, seen});
    wb(1'b1, 8'h14, 32'h28);
    wb(1'b1, 8'h10, 32'h3);
    exp_exc(6'h0f, 32'h0000003c, 1'b0);
    wb(1'b1, 8'h10, 32'h0);
    $display("test tick timer done");
    close_out();
  end
endmodule // tb_system_exception_sources
